//--- design/spm_pkg.sv
package spm_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h9a;
  localparam logic [7:0] ADDR_DAT = 8'h9b;
  localparam logic [7:0] ADDR_CKR = 8'h9d;
  localparam logic [7:0] ADDR_CTL = 8'hf8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h07;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CKR_RESET = 8'h00;
  localparam logic [7:0] DAT_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_PHA = 7;
  localparam int CFG_POL = 6;
  localparam int CFG_CNT_LSB = 3;
  localparam int CFG_LEN_LSB = 0;
  localparam int CTL_DONE = 7;
  localparam int CTL_CLASH = 6;
  localparam int CTL_CONF = 5;
  localparam int CTL_OVR = 4;
  localparam int CTL_BUSY = 3;
  localparam int CTL_SEL = 2;
  localparam int CTL_MST = 1;
  localparam int CTL_EN = 0;

  // ----------------------------------------------------------------
  // widths and states
  // ----------------------------------------------------------------
  localparam int DIV_W = 8;
  localparam int EDGE_W = 4;

  typedef enum logic {SPM_IDLE, SPM_RUN} spm_state_e;

endpackage

//--- design/spm_tick_if.sv
`timescale 1ns/10ps
interface spm_tick_if;
  logic run;
  logic [spm_pkg::DIV_W-1:0] div;
  logic tick;
  modport gen (input run, input div, output tick);
  modport user (output run, output div, input tick);
endinterface

//--- design/spm_clkgen.sv
`timescale 1ns/10ps
module spm_clkgen (
  input wire logic core_clk,
  input wire logic nrst,
  spm_tick_if.gen tk
);
  logic [spm_pkg::DIV_W-1:0] cnt;

  // one tick every div+1 cycles, so one sck half period
  assign tk.tick = tk.run && (cnt == tk.div);

  always_ff @(posedge core_clk) begin
    if (!nrst || !tk.run || tk.tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // spm_clkgen

//--- design/spm_top.sv
`timescale 1ns/10ps
// Function
// - phase picks first or second sampling edge
// - polarity sets idle sck level
// - read-only count of bits sent
// - master frame length is field plus one
// - master sck is half clock over divider+1
// - slave ignores divider, follows incoming sck
// - done flag on transfer end, software clears
// - clash flag on data write while busy
// - conflict flag when select low as master
// - overrun flag when buffer still unread
// - busy flag spans master transfer
// - selected flag is inverted chip select
// - master bit chooses master or slave
// - port disabled means no serial activity
// - master data write loads and starts
// - data read returns receive buffer
// - registers reset to documented values
// - both data lines carry msb first
// - conflict clears master and enable bits
// - colliding write dropped, transfer continues
// - unselected slave floats its data output
module spm_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic port_irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic cs_n_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic cfg_pha, cfg_pol;
  logic [2:0] cfg_len;
  logic [7:0] ckr;
  logic done, clash, conf, ovr, master_enable_bit, en;
  logic [7:0] sh, rx_buf;
  logic rx_full;
  spm_pkg::spm_state_e state, next_state;
  logic [spm_pkg::EDGE_W-1:0] edge_cnt;
  logic [2:0] bit_cnt;
  logic sck_lvl, mosi_q, miso_q;
  logic sck_m, sck_s, sck_p, nss_m, nss_s, nss_p, mosi_m, mosi_s;

  function automatic logic flag_next(input logic cur, input logic wr, input logic wv,
                                     input logic set);
    flag_next = set | (wr ? wv : cur);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr_cfg = sfr_wr && (sfr_addr == spm_pkg::ADDR_CFG);
  wire wr_dat = sfr_wr && (sfr_addr == spm_pkg::ADDR_DAT);
  wire wr_ckr = sfr_wr && (sfr_addr == spm_pkg::ADDR_CKR);
  wire wr_ctl = sfr_wr && (sfr_addr == spm_pkg::ADDR_CTL);
  wire rd_dat = sfr_rd && (sfr_addr == spm_pkg::ADDR_DAT);

  wire is_master = en && master_enable_bit;
  wire is_slave = en && !master_enable_bit;
  wire sel_flag = !nss_s;
  wire m_busy = (state == spm_pkg::SPM_RUN);
  wire s_active = is_slave && sel_flag;
  wire active = m_busy || s_active;
  wire conf_set = master_enable_bit && !nss_s;
  wire clash_set = wr_dat && active;
  wire m_start = wr_dat && is_master && !m_busy && !conf_set;
  wire s_load = wr_dat && is_slave && !sel_flag;

  spm_tick_if tk ();
  assign tk.run = m_busy;
  assign tk.div = ckr; // divider only reaches the master path

  spm_clkgen u_clkgen (
    .core_clk(core_clk),
    .nrst(nrst),
    .tk(tk)
  );

  // even edges are first edges of a bit period
  wire tick = tk.tick;
  wire m_sample = tick && (edge_cnt[0] == cfg_pha);
  wire m_shift = tick && (edge_cnt[0] != cfg_pha);
  wire m_end = tick && (edge_cnt == {cfg_len, 1'b1});
  wire s_edge = (sck_s != sck_p);
  wire s_lead = s_edge && (sck_s != cfg_pol);
  wire s_trail = s_edge && (sck_s == cfg_pol);
  wire s_sample = s_active && (cfg_pha ? s_trail : s_lead);
  wire s_shift = s_active && (cfg_pha ? s_lead : s_trail);
  wire s_begin = is_slave && !nss_s && nss_p;
  wire s_end = is_slave && nss_s && !nss_p;
  wire sample_in = m_busy ? miso_in : mosi_s;
  wire do_sample = (m_busy && m_sample) || s_sample;
  wire [7:0] next_sh = do_sample ? {sh[6:0], sample_in} : sh;
  wire xfer_end = (m_busy && m_end && !conf_set) || s_end;
  wire rx_take = xfer_end && !rx_full;
  wire ovr_set = xfer_end && rx_full;

  wire [7:0] cfg_rd = {cfg_pha, cfg_pol, bit_cnt, cfg_len};
  wire [7:0] ctl_rd = {done, clash, conf, ovr, m_busy, sel_flag, master_enable_bit, en};
  wire [7:0] rd_mux = (sfr_addr == spm_pkg::ADDR_CFG) ? cfg_rd :
                      (sfr_addr == spm_pkg::ADDR_DAT) ? rx_buf :
                      (sfr_addr == spm_pkg::ADDR_CKR) ? ckr :
                      (sfr_addr == spm_pkg::ADDR_CTL) ? ctl_rd : spm_pkg::RD_UNMAPPED;

  // ----------------------------------------------------------------
  // input synchronisers, first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      {sck_m, sck_s, sck_p} <= 3'h0;
      {nss_m, nss_s, nss_p} <= 3'h7;
      {mosi_m, mosi_s} <= 2'h0;
    end else begin
      {sck_m, sck_s, sck_p} <= {sck_in, sck_m, sck_s};
      {nss_m, nss_s, nss_p} <= {cs_n_in, nss_m, nss_s};
      {mosi_m, mosi_s} <= {mosi_in, mosi_m};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      {cfg_pha, cfg_pol} <= 2'h0;
      cfg_len <= spm_pkg::CFG_RESET[2:0];
      ckr <= spm_pkg::CKR_RESET;
      {done, clash, conf, ovr, master_enable_bit, en} <= 6'h00;
    end else begin
      if (wr_cfg) begin
        cfg_pha <= sfr_wdata[spm_pkg::CFG_PHA];
        cfg_pol <= sfr_wdata[spm_pkg::CFG_POL];
        cfg_len <= sfr_wdata[spm_pkg::CFG_LEN_LSB +: 3];
      end
      if (wr_ckr) begin
        ckr <= sfr_wdata;
      end
      // hardware set wins over a software clear in the same cycle
      done <= flag_next(done, wr_ctl, sfr_wdata[spm_pkg::CTL_DONE], xfer_end);
      clash <= flag_next(clash, wr_ctl, sfr_wdata[spm_pkg::CTL_CLASH], clash_set);
      conf <= flag_next(conf, wr_ctl, sfr_wdata[spm_pkg::CTL_CONF], conf_set);
      ovr <= flag_next(ovr, wr_ctl, sfr_wdata[spm_pkg::CTL_OVR], ovr_set);
      master_enable_bit <= conf_set ? 1'b0 : (wr_ctl ? sfr_wdata[spm_pkg::CTL_MST] : master_enable_bit);
      en <= conf_set ? 1'b0 : (wr_ctl ? sfr_wdata[spm_pkg::CTL_EN] : en);
    end
  end

  // ----------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      spm_pkg::SPM_IDLE: begin
        if (m_start) begin
          next_state = spm_pkg::SPM_RUN;
        end
      end
      spm_pkg::SPM_RUN: begin
        // a conflict or disable aborts the word without a done flag
        if (m_end || !is_master || conf_set) begin
          next_state = spm_pkg::SPM_IDLE;
        end
      end
      default: next_state = spm_pkg::SPM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= spm_pkg::SPM_IDLE;
      edge_cnt <= '0;
      sck_lvl <= 1'b0;
    end else begin
      state <= next_state;
      if (m_start) begin
        edge_cnt <= '0;
      end else if (m_busy && tick) begin
        edge_cnt <= edge_cnt + 1'b1;
      end
      if (m_busy && tick) begin
        sck_lvl <= ~sck_lvl;
      end else if (!m_busy) begin
        sck_lvl <= cfg_pol;
      end
    end
  end

  // ----------------------------------------------------------------
  // shifter, data lines, receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh <= spm_pkg::DAT_RESET;
      rx_buf <= spm_pkg::DAT_RESET;
      rx_full <= 1'b0;
      bit_cnt <= 3'h0;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      // a colliding write never reaches the shifter
      sh <= (m_start || s_load) ? sfr_wdata : next_sh;
      if (m_start || s_begin) begin
        bit_cnt <= 3'h0;
      end else if (do_sample) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (m_start) begin
        mosi_q <= sfr_wdata[7];
      end else if (m_busy && m_shift) begin
        mosi_q <= sh[7];
      end
      if (s_load) begin
        miso_q <= sfr_wdata[7];
      end else if (s_begin || s_shift) begin
        miso_q <= sh[7];
      end
      if (rx_take) begin
        rx_buf <= next_sh; // overrun keeps the old byte
      end
      rx_full <= rx_take | (rx_full & ~rd_dat);
      if (sfr_rd) begin
        sfr_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign sck_out = sck_lvl;
  assign sck_oe = is_master;
  assign mosi_out = mosi_q;
  assign mosi_oe = is_master;
  assign miso_out = miso_q;
  assign miso_oe = s_active;
  assign port_irq = done | clash | conf | ovr;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [7:0] gap, tgl;
  logic gap_ok;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      {gap, tgl} <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      gap <= (tick || !m_busy) ? 8'h00 : gap + 1'b1;
      gap_ok <= m_busy && (gap_ok || tick) && !m_start;
      tgl <= m_start ? 8'h00 : tgl + 8'(m_busy && tick);
    end
  end

  property p_idle_level;
    !m_busy |=> (sck_out == $past(cfg_pol));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("sck not at idle level");

  property p_rate;
    tick && gap_ok && $stable(ckr) |-> (gap == ckr);
  endproperty
  a_rate: assert property (p_rate) else $error("sck half period wrong");

  property p_start;
    m_start |=> m_busy && (sh == $past(sfr_wdata)) && (mosi_out == $past(sfr_wdata[7]));
  endproperty
  a_start: assert property (p_start) else $error("data write did not start");

  property p_clash;
    wr_dat && m_busy && is_master && !conf_set && !tick |=> clash && m_busy && port_irq;
  endproperty
  a_clash: assert property (p_clash) else $error("clash not flagged");

  property p_done;
    m_busy && m_end && !conf_set |=> done && !m_busy && port_irq;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing");

  property p_conf;
    master_enable_bit && !nss_s |=> conf && !master_enable_bit && !en && !sck_oe;
  endproperty
  a_conf: assert property (p_conf) else $error("conflict not handled");

  property p_sel;
    !$past(rd_dat) ##0 1'b1 |-> (sel_flag == !$past(cs_n_in, 2));
  endproperty
  a_sel: assert property (p_sel) else $error("selected flag wrong");

  property p_overrun;
    xfer_end && rx_full && !rd_dat |=> ovr && $stable(rx_buf);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_read;
    rd_dat |=> (sfr_rdata == $past(rx_buf));
  endproperty
  a_read: assert property (p_read) else $error("data read not buffer");

  property p_float;
    is_slave && nss_s |-> !miso_oe && !sck_oe && !mosi_oe;
  endproperty
  a_float: assert property (p_float) else $error("slave drives while unselected");

  property p_off;
    !en |-> (!sck_oe && !mosi_oe && !miso_oe) ##1 !m_busy;
  endproperty
  a_off: assert property (p_off) else $error("activity while disabled");

  property p_frame;
    m_busy && m_end && !conf_set |=> (tgl == {3'h0, cfg_len, 1'b0} + 8'h02);
  endproperty
  a_frame: assert property (p_frame) else $error("master frame length wrong");

  c_master_word: cover property (m_start ##[1:600] (m_busy && m_end));
  c_slave_word: cover property (s_begin ##[1:400] s_end);
  c_overrun: cover property (ovr_set);
  c_conflict: cover property (conf_set && m_busy);

endmodule // spm_top

//--- bench/spm_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// far-end slave for master transfers
// ----------------------------------------
module spm_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel,
  input wire logic pha,
  input wire logic pol,
  input wire logic [7:0] load_val,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
  end
  // first bit must be out before the first edge when sampling leads
  always @(posedge sel) begin
    sh = pha ? load_val : {load_val[6:0], 1'b0};
    miso = pha ? ~miso : load_val[7];
  end
  // released line shows no stale bit
  always @(negedge sel) miso = ~miso;
  always @(sck) begin
    if (sel && ((sck ^ pol) ^ pha)) begin
      got = {got[6:0], mosi};
    end else if (sel) begin
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
endmodule // spm_slave_model

//--- bench/spm_top_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module spm_top_tb;
  logic core_clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, p_load = 8'h00, p_got;
  logic port_irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, p_miso;
  logic cs_n_in = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0;
  logic p_sel = 1'b0, p_pha = 1'b0, p_pol = 1'b0, sck_q = 1'b0;
  int fails = 0, cmp_count = 0, cyc = 0, last = 0, per = 0, rises = 0;
  // ----------------------------------------
  // shared pins
  // ----------------------------------------
  wire sck_w = sck_oe ? sck_out : tb_sck;
  wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire miso_w = miso_oe ? miso_out : p_miso;
  always #20 core_clk = ~core_clk;
  spm_top dut_u (.core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port_irq(port_irq),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .cs_n_in(cs_n_in));
  spm_slave_model part_u (.sck(sck_w), .mosi(mosi_w), .sel(p_sel), .pha(p_pha),
    .pol(p_pol), .load_val(p_load), .miso(p_miso), .got(p_got));
  // sck period seen between rising edges, sampled off the active edge
  always @(negedge core_clk) begin
    cyc++;
    if (sck_out && !sck_q) begin
      per = cyc - last;
      last = cyc;
      rises++;
    end
    sck_q = sck_out;
  end
  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(posedge core_clk);
    d = sfr_rdata;
  endtask
  task automatic wait_done(output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < 2000 && v[7] !== 1'b1; i++) rd(spm_pkg::ADDR_CTL, v);
  endtask
  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // one master frame against the far-end model
  // ----------------------------------------
  task automatic mxfer(input logic [7:0] cfg, input logic [7:0] ckr, input logic [7:0] wd,
                       input logic [7:0] pd);
    int n;
    logic [7:0] v, m;
    n = int'(cfg[2:0]) + 1;
    m = 8'hff >> (8 - n);
    wr(spm_pkg::ADDR_CTL, 8'h00);
    wr(spm_pkg::ADDR_CFG, cfg);
    wr(spm_pkg::ADDR_CKR, ckr);
    p_pha <= cfg[7];
    p_pol <= cfg[6];
    p_load <= pd;
    wr(spm_pkg::ADDR_CTL, 8'h03);
    repeat (2) @(negedge core_clk);
    `CHK("sck idle", cfg[6], sck_out)
    `CHK("sck drive", 2'b11, {sck_oe, mosi_oe})
    p_sel <= 1'b1;
    wr(spm_pkg::ADDR_DAT, wd);
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("busy", 1'b1, v[3])
    wr(spm_pkg::ADDR_DAT, ~wd);
    wait_done(v);
    `CHK("done clash busy", 3'b110, {v[7:6], v[3]})
    `CHK("irq", 1'b1, port_irq)
    `CHK("mosi word", (wd >> (8 - n)) & m, p_got & m)
    rd(spm_pkg::ADDR_DAT, v);
    `CHK("rx word", (pd >> (8 - n)) & m, v & m)
    rd(spm_pkg::ADDR_CFG, v);
    `CHK("bit index", 3'(n % 8), v[5:3])
    if (n > 1) `CHK("sck period", 2 * (int'(ckr) + 1), per)
    wr(spm_pkg::ADDR_CTL, 8'h03);
    p_sel <= 1'b0;
  endtask
  // ----------------------------------------
  // one slave frame, bench plays the far master
  // ----------------------------------------
  task automatic sxfer(input logic [7:0] cfg, input logic [7:0] ld, input logic [7:0] mo);
    logic [7:0] v, m;
    m = 8'h00;
    wr(spm_pkg::ADDR_CTL, 8'h00);
    tb_sck <= cfg[6];
    wr(spm_pkg::ADDR_CKR, 8'hff);
    wr(spm_pkg::ADDR_CFG, cfg);
    wr(spm_pkg::ADDR_CTL, 8'h01);
    wr(spm_pkg::ADDR_DAT, ld);
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("miso float", 1'b0, miso_oe)
    cs_n_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("selected", 1'b1, v[2])
    `CHK("miso drive", 1'b1, miso_oe)
    wr(spm_pkg::ADDR_DAT, 8'h11);
    // leading edge first, then trailing; data set up half a bit early
    for (int i = 7; i >= 0; i--) begin
      if (!cfg[7]) tb_mosi <= mo[i];
      repeat (8) @(posedge core_clk);
      if (!cfg[7]) m[i] = miso_w;
      tb_sck <= ~cfg[6];
      if (cfg[7]) tb_mosi <= mo[i];
      repeat (8) @(posedge core_clk);
      if (cfg[7]) m[i] = miso_w;
      tb_sck <= cfg[6];
    end
    repeat (8) @(posedge core_clk);
    cs_n_in <= 1'b1;
    wait_done(v);
    `CHK("slave flags", 3'b110, {v[7:6], v[3]})
    `CHK("miso word", ld, m)
    rd(spm_pkg::ADDR_DAT, v);
    `CHK("slave rx", mo, v)
    `CHK("miso off", 1'b0, miso_oe)
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
  initial begin
    logic [7:0] v;
    int n0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    rd(spm_pkg::ADDR_CFG, v);
    `CHK("cfg reset", 8'h07, v)
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("ctl reset", 8'h00, v)
    rd(spm_pkg::ADDR_CKR, v);
    `CHK("ckr reset", 8'h00, v)
    rd(spm_pkg::ADDR_DAT, v);
    `CHK("dat reset", 8'h00, v)
    rd(8'h9c, v);
    `CHK("unmapped", 8'h00, v)
    `CHK("sck off", 1'b0, sck_oe)
    mxfer(8'h07, 8'h00, 8'ha5, 8'h3c);
    mxfer(8'h47, 8'h01, 8'h5b, 8'hc6);
    mxfer(8'h83, 8'h03, 8'he1, 8'h96);
    mxfer(8'hc0, 8'h03, 8'h80, 8'h80);
    mxfer(8'hc7, 8'h02, 8'h69, 8'h0f);
    // overrun: second frame lands while first still unread
    @(posedge core_clk);
    p_load <= 8'h5a;
    p_sel <= 1'b1;
    wr(spm_pkg::ADDR_DAT, 8'h00);
    wait_done(v);
    wr(spm_pkg::ADDR_CTL, 8'h03);
    wr(spm_pkg::ADDR_DAT, 8'h00);
    wait_done(v);
    `CHK("overrun", 1'b1, v[4])
    rd(spm_pkg::ADDR_DAT, v);
    `CHK("kept rx", 8'h5a, v)
    wr(spm_pkg::ADDR_CTL, 8'h03);
    p_sel <= 1'b0;
    cs_n_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("conflict", 8'h24, v)
    `CHK("conflict irq", 1'b1, port_irq)
    `CHK("sck released", 1'b0, sck_oe)
    cs_n_in <= 1'b1;
    // slave: divider and length must not matter
    sxfer(8'h00, 8'h96, 8'hc3);
    sxfer(8'hc2, 8'h5c, 8'h3a);
    wr(spm_pkg::ADDR_CTL, 8'h00);
    n0 = rises;
    wr(spm_pkg::ADDR_DAT, 8'h55);
    repeat (40) @(posedge core_clk);
    rd(spm_pkg::ADDR_CTL, v);
    `CHK("off ctl", 8'h00, v)
    `CHK("off sck", n0, rises)
    `CHK("off oe", 3'b000, {sck_oe, mosi_oe, miso_oe})
    print_verdict();
  end
endmodule // spm_top_tb
